// ===== rtl/ccdl_top.sv
// Purpose: Power-on switch capture and status indicator logic of a coupler
// Assumes: 200 MHz clock; fault reports come from the module-bus scanner
// Notes: Indicators are active high drive levels
//
// Function
// - Switches 7 and 8 select 125, 250, 500 or default 125 kbaud.
// - Switches 1 to 6 form the node address, switch 1 least significant.
// - Every node address from 0 to 63 is accepted.
// - Switches are captured only at power-on.
// - Red I/O indicator off after clean start, blinks on module error.
// - Error shown as fast preamble, code pulses, then argument pulses.
// - Code 1 arguments: checksum 0, code overflow 1, data type 2.
// - Code 2: argument 0 programmed config, n table mismatch at module n.
// - Command error 3/0, data error 4/0, fieldbus error 6/0.
// - Chain break after module n is 4 pulses, argument n.
// - Register communication fault at module n is 5 pulses, argument n.
// - Argument counts last module before fault, skipping passive modules.
// - Latched errors hold stop state until power cycle or scanner reset.
// - Diagnosis only at power-up, on scanner reset from stop, or on fieldbus access.
// - Module status: green blink while configuring, green ok, red blink, red.
// - Network status green blink online, steady green when allocated.
// - Network status blinks red on I/O connection timeout.
// - Network status steady red on bus-off.
// - I/O green when modules work, red blinks the error code on module bus fault.
// - Red I/O indicator blinks while modules are being configured.
// - Start-up error enters stop; clean start enters fieldbus start.

`timescale 1ns/100ps

module ccdl_top
   import ccdl_pkg::*;
#(
   parameter int unsigned FAST_CYC = FAST_HALF_CYC,
   parameter int unsigned SLOW_CYC = SLOW_HALF_CYC,
   parameter int unsigned GAP_CYC = GROUP_GAP_CYC,
   parameter int unsigned STAT_CYC = STAT_HALF_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Switch pins
   input wire logic [7:0] switch_i,
   // Module scan interface
   output logic scan_start_o,
   input wire logic scan_done_i,
   input wire logic [3:0] scan_fault_i,
   input wire logic [6:0] scan_pos_i,
   input wire logic scan_fault_sticky_i,
   // Fieldbus side
   input wire logic fb_access_i,
   input wire logic scanner_reset_i,
   input wire logic online_i,
   input wire logic allocated_i,
   input wire logic io_timeout_i,
   input wire logic bus_off_i,
   input wire logic queue_overflow_i,
   // Captured configuration and operating state
   output logic [5:0] node_addr_o,
   output logic [1:0] bit_rate_o,
   output logic fb_start_o,
   output logic stopped_o,
   // Indicators
   output logic module_status_indicator_green_o,
   output logic module_status_indicator_red_o,
   output logic network_status_indicator_green_o,
   output logic network_status_indicator_red_o,
   output logic queue_overflow_indicator_o,
   output logic io_run_led_o,
   output logic io_err_led_o
);

   // ******************************
   // Reset release and pin sync
   // ******************************
   logic rst_meta;
   logic rst_n;
   logic [7:0] sw_meta;
   logic [7:0] sw_sync;
   logic captured;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pin sync runs through reset, so the capture just after release
   // sees the settled switches rather than a reset value
   always_ff @(posedge clk_i) begin
      sw_meta <= switch_i;
      sw_sync <= sw_meta;
   end

   // ******************************
   // Power-on capture
   // ******************************
   function automatic logic [1:0] rate_decode(input logic s7, input logic s8);
      case ({s8, s7})
         2'b01: rate_decode = RATE_250K;
         2'b10: rate_decode = RATE_500K;
         default: rate_decode = RATE_125K;
      endcase
   endfunction

   // capture once
   // Scanner reset does not recapture: only a power cycle does
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         captured <= 1'b0;
         node_addr_o <= 6'h00;
         bit_rate_o <= RATE_125K;
      end else if (!captured) begin
         captured <= 1'b1;
         node_addr_o <= sw_sync[ADDR_MSB:ADDR_LSB];
         bit_rate_o <= rate_decode(sw_sync[RATE_SW7], sw_sync[RATE_SW8]);
      end
   end

   // ******************************
   // Timing enables
   // ******************************
   logic fast_tick;
   logic slow_tick;
   logic gap_tick;
   logic stat_tick;
   logic stat_blink;

   ccdl_tick #(.N(FAST_CYC)) u_fast (
      .clk_i(clk_i), .rst_n_i(rst_n), .tick_o(fast_tick));
   ccdl_tick #(.N(SLOW_CYC)) u_slow (
      .clk_i(clk_i), .rst_n_i(rst_n), .tick_o(slow_tick));
   ccdl_tick #(.N(GAP_CYC)) u_gap (
      .clk_i(clk_i), .rst_n_i(rst_n), .tick_o(gap_tick));
   ccdl_tick #(.N(STAT_CYC)) u_stat (
      .clk_i(clk_i), .rst_n_i(rst_n), .tick_o(stat_tick));

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         stat_blink <= 1'b0;
      end else if (stat_tick) begin
         stat_blink <= !stat_blink;
      end
   end

   // ******************************
   // Fault to blink code mapping
   // ******************************
   // code 1 arguments
   // position from scanner, passive modules skipped
   function automatic logic [10:0] fault_map(input logic [3:0] f,
                                             input logic [6:0] pos);
      case (f)
         FAULT_CHECKSUM: fault_map = {CODE_INTERNAL, ARG_CHECKSUM};
         FAULT_CODE_OVFL: fault_map = {CODE_INTERNAL, ARG_CODE_OVFL};
         FAULT_DATA_TYPE: fault_map = {CODE_INTERNAL, ARG_DATA_TYPE};
         FAULT_PROG_CFG: fault_map = {CODE_CONFIG, ARG_ZERO};
         FAULT_TABLE: fault_map = {CODE_CONFIG, pos};
         FAULT_CMD: fault_map = {CODE_CMD, ARG_ZERO};
         FAULT_DATA: fault_map = {CODE_DATA_BREAK, ARG_ZERO};
         FAULT_BREAK: fault_map = {CODE_DATA_BREAK, pos};
         FAULT_REG_COMM: fault_map = {CODE_REG_COMM, pos};
         FAULT_FIELDBUS: fault_map = {CODE_FIELDBUS, ARG_ZERO};
         default: fault_map = {CODE_NONE, ARG_ZERO};
      endcase
   endfunction

   // ******************************
   // Operating state
   // ******************************
   ccdl_state_e state;
   logic [3:0] err_code;
   logic [6:0] err_arg;
   logic err_sticky;
   logic fault_seen;

   assign fault_seen = scan_done_i && (scan_fault_i != FAULT_NONE);

   // diagnosis at power-up or fieldbus access
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= CCDL_ST_RESET;
         err_code <= CODE_NONE;
         err_arg <= ARG_ZERO;
         err_sticky <= 1'b0;
         scan_start_o <= 1'b0;
      end else begin
         scan_start_o <= 1'b0;
         case (state)
            CCDL_ST_RESET: begin
               scan_start_o <= 1'b1;
               state <= CCDL_ST_SCAN;
            end
            CCDL_ST_SCAN, CCDL_ST_RESCAN: if (scan_done_i) begin
               if (fault_seen) begin
                  {err_code, err_arg} <= fault_map(scan_fault_i, scan_pos_i);
                  err_sticky <= scan_fault_sticky_i;
                  state <= CCDL_ST_STOP;
               end else begin
                  err_code <= CODE_NONE;
                  state <= CCDL_ST_FB_START;
               end
            end
            CCDL_ST_FB_START: if (fb_access_i) begin
               scan_start_o <= 1'b1;
               state <= CCDL_ST_RESCAN;
            end
            CCDL_ST_STOP: begin
               if (scanner_reset_i) begin
                  err_code <= CODE_NONE;
                  err_sticky <= 1'b0;
                  state <= CCDL_ST_RESET;
               end else if (fb_access_i && !err_sticky) begin
                  scan_start_o <= 1'b1;
                  state <= CCDL_ST_RESCAN;
               end
            end
            default: state <= CCDL_ST_RESET;
         endcase
      end
   end

   assign fb_start_o = (state == CCDL_ST_FB_START);
   assign stopped_o = (state == CCDL_ST_STOP);

   // ******************************
   // Blink code and indicators
   // ******************************
   logic code_led;
   logic configuring;
   logic err_shown;

   assign configuring = (state == CCDL_ST_RESET) || (state == CCDL_ST_SCAN);
   // A rescan keeps showing the old code until it completes
   assign err_shown = (err_code != CODE_NONE);

   ccdl_blink u_blink (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .fast_tick_i(fast_tick),
      .slow_tick_i(slow_tick),
      .gap_tick_i(gap_tick),
      .enable_i(err_shown),
      .code_i(err_code),
      .arg_i(err_arg),
      .led_o(code_led)
   );

   // Indicator outputs are registered to avoid glitches on the pins
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         io_err_led_o <= 1'b0;
         io_run_led_o <= 1'b0;
         module_status_indicator_green_o <= 1'b0;
         module_status_indicator_red_o <= 1'b0;
         queue_overflow_indicator_o <= 1'b0;
         network_status_indicator_green_o <= 1'b0;
         network_status_indicator_red_o <= 1'b0;
      end else begin
         // status blink while configuring, off when clean, code when faulty
         if (configuring) begin
            io_err_led_o <= stat_blink;
         end else begin
            io_err_led_o <= err_shown && code_led;
         end
         io_run_led_o <= fb_start_o;
         module_status_indicator_green_o <=
            !err_shown && !queue_overflow_i &&
            (configuring ? stat_blink : 1'b1);
         module_status_indicator_red_o <= queue_overflow_i ||
            (err_shown && stat_blink);
         queue_overflow_indicator_o <= queue_overflow_i ||
            (err_shown && stat_blink);
         if (bus_off_i) begin
            network_status_indicator_red_o <= 1'b1;
            network_status_indicator_green_o <= 1'b0;
         end else if (io_timeout_i) begin
            network_status_indicator_red_o <= stat_blink;
            network_status_indicator_green_o <= 1'b0;
         end else begin
            network_status_indicator_red_o <= 1'b0;
            network_status_indicator_green_o <= allocated_i ||
               (online_i && stat_blink);
         end
      end
   end

endmodule // ccdl_top

// ===== rtl/ccdl_pkg.sv
// Purpose: Shared constants for the coupler configuration and indicator block
// Assumes: 200 MHz system clock
// Notes: Blink timing is given as times in ms and derived into cycle counts

package ccdl_pkg;

   // ******************************
   // Clock and timing
   // ******************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned FAST_HALF_MS = 50;
   localparam int unsigned SLOW_HALF_MS = 250;
   localparam int unsigned GROUP_GAP_MS = 1000;
   localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
   localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
   localparam int unsigned GROUP_GAP_CYC = CLK_HZ / 1000 * GROUP_GAP_MS;
   localparam int unsigned PREAMBLE_FLASHES = 8;
   localparam int unsigned STAT_HALF_MS = 250;
   localparam int unsigned STAT_HALF_CYC = CLK_HZ / 1000 * STAT_HALF_MS;

   // ******************************
   // Switch fields
   // ******************************
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 5;
   localparam int RATE_SW7 = 6;
   localparam int RATE_SW8 = 7;

   // ******************************
   // Bit-rate encodings
   // ******************************
   localparam logic [1:0] RATE_125K = 2'h0;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] RATE_500K = 2'h2;
   localparam logic [7:0] SWITCH_RESET = 8'h00;

   // ******************************
   // Error codes and arguments
   // ******************************
   localparam logic [3:0] CODE_NONE = 4'h0;
   localparam logic [3:0] CODE_INTERNAL = 4'h1;
   localparam logic [3:0] CODE_CONFIG = 4'h2;
   localparam logic [3:0] CODE_CMD = 4'h3;
   localparam logic [3:0] CODE_DATA_BREAK = 4'h4;
   localparam logic [3:0] CODE_REG_COMM = 4'h5;
   localparam logic [3:0] CODE_FIELDBUS = 4'h6;
   localparam logic [6:0] ARG_CHECKSUM = 7'h00;
   localparam logic [6:0] ARG_CODE_OVFL = 7'h01;
   localparam logic [6:0] ARG_DATA_TYPE = 7'h02;
   localparam logic [6:0] ARG_ZERO = 7'h00;

   // ******************************
   // Fault kinds reported by the module scan
   // ******************************
   localparam logic [3:0] FAULT_NONE = 4'h0;
   localparam logic [3:0] FAULT_CHECKSUM = 4'h1;
   localparam logic [3:0] FAULT_CODE_OVFL = 4'h2;
   localparam logic [3:0] FAULT_DATA_TYPE = 4'h3;
   localparam logic [3:0] FAULT_PROG_CFG = 4'h4;
   localparam logic [3:0] FAULT_TABLE = 4'h5;
   localparam logic [3:0] FAULT_CMD = 4'h6;
   localparam logic [3:0] FAULT_DATA = 4'h7;
   localparam logic [3:0] FAULT_BREAK = 4'h8;
   localparam logic [3:0] FAULT_REG_COMM = 4'h9;
   localparam logic [3:0] FAULT_FIELDBUS = 4'ha;

   // ******************************
   // Coupler operating states
   // ******************************
   typedef enum logic [4:0] {
      CCDL_ST_RESET = 5'h01,
      CCDL_ST_SCAN = 5'h02,
      CCDL_ST_FB_START = 5'h04,
      CCDL_ST_STOP = 5'h08,
      CCDL_ST_RESCAN = 5'h10
   } ccdl_state_e;

   // Blink code sequencer phases
   typedef enum logic [4:0] {
      CCDL_BK_IDLE = 5'h01,
      CCDL_BK_PRE = 5'h02,
      CCDL_BK_CODE = 5'h04,
      CCDL_BK_ARG = 5'h08,
      CCDL_BK_GAP = 5'h10
   } ccdl_blink_e;

endpackage

// ===== rtl/ccdl_tick.sv
// Purpose: Free-running divider giving a one-cycle enable every N cycles
// Assumes: Synchronous reset copy from the top
// Notes: N must be at least one

`timescale 1ns/100ps

module ccdl_tick #(
   parameter int unsigned N = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Enable out
   output logic tick_o
);

   logic [31:0] count;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= 32'h0;
      end else if (count >= N - 1) begin
         count <= 32'h0;
      end else begin
         count <= count + 32'h1;
      end
   end

   assign tick_o = (count >= N - 1);

endmodule // ccdl_tick

// ===== rtl/ccdl_blink.sv
// Purpose: Blink code generator: fast preamble, code group, argument group
// Assumes: Enables come from dividers on the same clock
// Notes: Code and argument are sampled at the start of each repetition

`timescale 1ns/100ps

module ccdl_blink
   import ccdl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Timing enables
   input wire logic fast_tick_i,
   input wire logic slow_tick_i,
   input wire logic gap_tick_i,
   // Code to show
   input wire logic enable_i,
   input wire logic [3:0] code_i,
   input wire logic [6:0] arg_i,
   // Indicator
   output logic led_o
);

   ccdl_blink_e phase;
   logic [7:0] remain;
   logic [3:0] code;
   logic [6:0] arg;
   logic half;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= CCDL_BK_IDLE;
         remain <= 8'h00;
         code <= 4'h0;
         arg <= 7'h00;
         half <= 1'b0;
         led_o <= 1'b0;
      end else if (!enable_i) begin
         phase <= CCDL_BK_IDLE;
         half <= 1'b0;
         led_o <= 1'b0;
      end else begin
         case (phase)
            CCDL_BK_IDLE: begin
               code <= code_i;
               arg <= arg_i;
               remain <= 8'(PREAMBLE_FLASHES);
               half <= 1'b0;
               phase <= CCDL_BK_PRE;
            end
            CCDL_BK_PRE: if (fast_tick_i) begin
               led_o <= !half;
               half <= !half;
               if (half) begin
                  if (remain <= 8'h01) begin
                     remain <= {4'h0, code};
                     phase <= CCDL_BK_CODE;
                  end else begin
                     remain <= remain - 8'h01;
                  end
               end
            end
            CCDL_BK_CODE: if (slow_tick_i) begin
               // A group with no pulses passes straight on
               if (remain == 8'h00) begin
                  led_o <= 1'b0;
                  half <= 1'b0;
                  remain <= {1'b0, arg};
                  phase <= CCDL_BK_ARG;
               end else begin
                  led_o <= !half;
                  half <= !half;
                  if (half) begin
                     remain <= remain - 8'h01;
                  end
               end
            end
            CCDL_BK_ARG: if (slow_tick_i) begin
               if (remain == 8'h00) begin
                  led_o <= 1'b0;
                  half <= 1'b0;
                  phase <= CCDL_BK_GAP;
               end else begin
                  led_o <= !half;
                  half <= !half;
                  if (half) begin
                     remain <= remain - 8'h01;
                  end
               end
            end
            CCDL_BK_GAP: if (gap_tick_i) begin
               phase <= CCDL_BK_IDLE;
            end
            default: begin
               phase <= CCDL_BK_IDLE;
               led_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // ccdl_blink

// ===== tb/ccdl_props.sv
// Purpose: Port assertions for the coupler indicator block
// Assumes: One clock; reset_n_i is the raw power-on reset
// Notes: Bound into every ccdl_top instance below

`timescale 1ns/100ps

module ccdl_props
   import ccdl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Scan and fieldbus side
   input wire logic scan_start_o,
   input wire logic scan_done_i,
   input wire logic [3:0] scan_fault_i,
   input wire logic fb_access_i,
   input wire logic scanner_reset_i,
   input wire logic bus_off_i,
   // Outputs under watch
   input wire logic [5:0] node_addr_o,
   input wire logic [1:0] bit_rate_o,
   input wire logic fb_start_o,
   input wire logic stopped_o,
   input wire logic network_status_indicator_red_o,
   input wire logic io_err_led_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // Internal reset lags the pin, so level checks wait for settling
   logic [3:0] up_cnt;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         up_cnt <= 4'h0;
      else if (up_cnt != 4'hf)
         up_cnt <= up_cnt + 4'h1;
   end

   sequence s_restart;
      !stopped_o ##[1:2] scan_start_o;
   endsequence

   cfg_hold_a: assert property (
      up_cnt == 4'hf |-> $stable(node_addr_o) && $stable(bit_rate_o))
      else $error("captured switches changed");
   rate_code_a: assert property (
      up_cnt == 4'hf |-> bit_rate_o != 2'h3) else $error("bad rate code");
   stop_fault_a: assert property (
      scan_done_i && scan_fault_i != FAULT_NONE |=> stopped_o)
      else $error("no stop after fault");
   start_clean_a: assert property (
      scan_done_i && scan_fault_i == FAULT_NONE |=> fb_start_o && !stopped_o)
      else $error("no fieldbus start");
   err_off_a: assert property (
      fb_start_o [*3] |-> !io_err_led_o) else $error("error led lit");
   rediag_a: assert property (
      fb_start_o && fb_access_i |-> ##[1:6] scan_start_o)
      else $error("no diagnosis on access");
   restart_a: assert property (
      stopped_o && scanner_reset_i |=> s_restart)
      else $error("scanner reset ignored");
   stop_hold_a: assert property (
      stopped_o && !scanner_reset_i && !fb_access_i |=> stopped_o)
      else $error("stop left alone");
   bus_off_a: assert property (
      (bus_off_i && up_cnt == 4'hf) [*3] |-> network_status_indicator_red_o)
      else $error("bus off not red");
endmodule // ccdl_props

bind ccdl_top ccdl_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .scan_start_o(scan_start_o), .scan_done_i(scan_done_i),
   .scan_fault_i(scan_fault_i), .fb_access_i(fb_access_i),
   .scanner_reset_i(scanner_reset_i), .bus_off_i(bus_off_i),
   .node_addr_o(node_addr_o), .bit_rate_o(bit_rate_o),
   .fb_start_o(fb_start_o), .stopped_o(stopped_o),
   .network_status_indicator_red_o(network_status_indicator_red_o),
   .io_err_led_o(io_err_led_o));

// ===== tb/ccdl_scan_model.sv
// Purpose: Behavioural module scanner on the far side of the coupler
// Assumes: Coupler asks for a scan with a one-cycle request
// Notes: Fault fields mean something only with the done pulse

`timescale 1ns/100ps

module ccdl_scan_model (
   // Clock
   input wire logic clk_i,
   // Request and wanted outcome
   input wire logic start_i,
   input wire logic [3:0] fault_cfg_i,
   input wire logic [6:0] pos_cfg_i,
   input wire logic sticky_cfg_i,
   input wire logic slow_i,
   // Report
   output logic done_o,
   output logic [3:0] fault_o,
   output logic [6:0] pos_o,
   output logic sticky_o
);
   initial begin
      done_o = 1'b0;
      fault_o = 4'hf;
      pos_o = 7'h7f;
      sticky_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (start_i === 1'b1) begin
            repeat (slow_i ? 60 : 2) @(negedge clk_i);
            done_o = 1'b1;
            fault_o = fault_cfg_i;
            pos_o = pos_cfg_i;
            sticky_o = sticky_cfg_i;
            @(negedge clk_i);
            // Stale fields are inverted so nothing relies on them
            done_o = 1'b0;
            fault_o = ~fault_o;
            pos_o = ~pos_o;
            sticky_o = ~sticky_o;
         end
      end
   end
endmodule // ccdl_scan_model

// ===== tb/ccdl_top_tb.sv
// Purpose: Self-checking bench for ccdl_top
// Assumes: Short blink parameters; scanner model answers each scan
// Notes: Inputs change on the falling edge

`timescale 1ns/100ps

module ccdl_top_tb import ccdl_pkg::*;;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] switch_i = 8'h00;
   logic fb_access_i = 1'b0;
   logic scanner_reset_i = 1'b0;
   logic [4:0] net_i = 5'h00;
   logic [3:0] cfg_fault = FAULT_NONE;
   logic [6:0] cfg_pos = 7'h00;
   logic cfg_slow = 1'b0;
   logic cfg_sticky = 1'b1;
   logic [1:0] pat;
   wire scan_start, scan_done, sticky, fb_start, stopped;
   wire [3:0] fault;
   wire [6:0] pos, led;
   wire [5:0] addr;
   wire [1:0] rate;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int i;
   logic [7:0] sw_tab [4] = '{8'h00, 8'h7f, 8'haa, 8'hff};
   logic [3:0] f_tab [10] = '{FAULT_CHECKSUM, FAULT_CODE_OVFL,
      FAULT_DATA_TYPE, FAULT_PROG_CFG, FAULT_TABLE, FAULT_CMD, FAULT_DATA,
      FAULT_BREAK, FAULT_REG_COMM, FAULT_FIELDBUS};
   logic [6:0] p_tab [10] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h05, 7'h00,
      7'h00, 7'h03, 7'h02, 7'h00};
   // Slow pulses per repetition: code count plus argument count
   logic [7:0] s_tab [10] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h07, 8'h03,
      8'h04, 8'h07, 8'h07, 8'h06};
   // {online, allocated, timeout, bus off, overflow}; led; high/low seen
   logic [4:0] n_in [7] = '{5'h10, 5'h18, 5'h18, 5'h1c, 5'h1e, 5'h19, 5'h19};
   int n_sel [7] = '{0, 0, 2, 1, 1, 3, 4};
   logic [1:0] n_pat [7] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2};

   ccdl_top #(.FAST_CYC(4), .SLOW_CYC(8), .GAP_CYC(16), .STAT_CYC(8)) dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .switch_i(switch_i),
      .scan_start_o(scan_start), .scan_done_i(scan_done),
      .scan_fault_i(fault), .scan_pos_i(pos), .scan_fault_sticky_i(sticky),
      .fb_access_i(fb_access_i), .scanner_reset_i(scanner_reset_i),
      .online_i(net_i[4]), .allocated_i(net_i[3]), .io_timeout_i(net_i[2]),
      .bus_off_i(net_i[1]), .queue_overflow_i(net_i[0]),
      .node_addr_o(addr), .bit_rate_o(rate), .fb_start_o(fb_start),
      .stopped_o(stopped), .module_status_indicator_green_o(led[2]),
      .module_status_indicator_red_o(led[3]),
      .network_status_indicator_green_o(led[0]),
      .network_status_indicator_red_o(led[1]),
      .queue_overflow_indicator_o(led[4]), .io_run_led_o(led[5]),
      .io_err_led_o(led[6]));

   ccdl_scan_model scanner (.clk_i(clk_i), .start_i(scan_start),
      .fault_cfg_i(cfg_fault), .pos_cfg_i(cfg_pos), .sticky_cfg_i(cfg_sticky),
      .slow_i(cfg_slow), .done_o(scan_done), .fault_o(fault), .pos_o(pos),
      .sticky_o(sticky));

   always #2.5 clk_i = ~clk_i;

   task end_sim;
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [1:0] rate_of(input logic [7:0] sw);
      case (sw[7:6])
         2'b01: rate_of = RATE_250K;
         2'b10: rate_of = RATE_500K;
         default: rate_of = RATE_125K;
      endcase
   endfunction

   task reset_pulse(input logic [7:0] sw);
      @(negedge clk_i);
      reset_n_i = 1'b0;
      switch_i = sw;
      repeat (3) @(negedge clk_i);
      reset_n_i = 1'b1;
   endtask

   task wait_up;
      int k;
      for (k = 0; k < 200 && fb_start !== 1'b1 && stopped !== 1'b1; k++)
         @(negedge clk_i);
   endtask

   // Bit 1: led seen lit, bit 0: seen dark, over 40 cycles, two and a half status periods
   task watch(input int s);
      pat = 2'h0;
      repeat (40) begin
         @(negedge clk_i);
         pat = pat | (led[s] === 1'b1 ? 2'h2 : 2'h1);
      end
   endtask

   task run_len(output logic is_slow);
      int k, hi;
      hi = 0;
      // Skip a pulse already under way so it is not measured short
      for (k = 0; k < 400 && led[6] === 1'b1; k++) @(negedge clk_i);
      for (k = 0; k < 400 && led[6] !== 1'b1; k++) @(negedge clk_i);
      for (k = 0; k < 400 && led[6] === 1'b1; k++) begin
         hi++;
         @(negedge clk_i);
      end
      is_slow = hi >= 6;
   endtask

   // Aligns on the first slow pulse after the preamble, then counts
   task blink_code(input logic [7:0] n_slow);
      logic s;
      int ns, nf, k;
      ns = 0;
      nf = 0;
      s = 1'b1;
      for (k = 0; k < 60 && s; k++) run_len(s);
      for (k = 0; k < 60 && !s; k++) run_len(s);
      for (k = 0; k < 60 && s; k++) begin
         ns++;
         run_len(s);
      end
      for (k = 0; k < 60 && !s; k++) begin
         nf++;
         run_len(s);
      end
      check(8'(ns), n_slow);
      check(8'(nf), 8'h08);
   endtask

   initial begin
      cfg_slow = 1'b1;
      reset_pulse(8'h00);
      watch(6);
      check(pat, 2'h3);
      wait_up();
      cfg_slow = 1'b0;
      for (i = 0; i < 4; i++) begin
         reset_pulse(sw_tab[i]);
         wait_up();
         check(addr, sw_tab[i][5:0]);
         check(rate, rate_of(sw_tab[i]));
         check(fb_start, 1'b1);
      end
      repeat (4) @(negedge clk_i);
      check(led[6], 1'b0);
      check(led[5], 1'b1);
      switch_i = 8'h15;
      for (i = 0; i < 7; i++) begin
         net_i = n_in[i];
         repeat (4) @(negedge clk_i);
         watch(n_sel[i]);
         check(pat, n_pat[i]);
      end
      net_i = 5'h00;
      check(addr, 6'h3f);
      check(rate, RATE_125K);
      // Fault only shows once the fieldbus asks for diagnosis
      cfg_fault = FAULT_CMD;
      repeat (50) @(negedge clk_i);
      check(fb_start, 1'b1);
      fb_access_i = 1'b1;
      @(negedge clk_i);
      fb_access_i = 1'b0;
      wait_up();
      repeat (4) @(negedge clk_i);
      check(stopped, 1'b1);
      watch(3);
      check(pat, 2'h3);
      cfg_fault = FAULT_NONE;
      fb_access_i = 1'b1;
      @(negedge clk_i);
      fb_access_i = 1'b0;
      repeat (20) @(negedge clk_i);
      check(stopped, 1'b1);
      blink_code(8'h03);
      scanner_reset_i = 1'b1;
      @(negedge clk_i);
      scanner_reset_i = 1'b0;
      wait_up();
      check(fb_start, 1'b1);
      check(addr, 6'h3f);
      for (i = 0; i < 10; i++) begin
         cfg_fault = f_tab[i];
         cfg_pos = p_tab[i];
         cfg_slow = i[0];
         cfg_sticky = (i != 9);
         reset_pulse(8'h00);
         wait_up();
         check(stopped, 1'b1);
         blink_code(s_tab[i]);
      end
      blink_code(s_tab[9]);
      // A non-latching fault leaves stop on the next fieldbus access
      cfg_fault = FAULT_NONE;
      fb_access_i = 1'b1;
      @(negedge clk_i);
      fb_access_i = 1'b0;
      wait_up();
      check(fb_start, 1'b1);
      end_sim();
   end
endmodule // ccdl_top_tb
